// *** css_osc_model.sv ***
// Free-running oscillator and start-up timer model feeding the switch.
`default_nettype none

module css_osc_model (
  output logic primary_clk_in,
  output logic secondary_clk_in,
  output logic fast_internal_osc,
  output logic slow_internal_osc,
  output logic oscillator_startup_timer_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Sources
  // ---------------------------------------------------------------
  // Edges sit 2 ns after a multiple of 8 ns so the oversampled periods are exact.
  // The watch crystal runs from time zero, so it is stable before any switch.
  initial
  begin
    primary_clk_in = 1'b0;
    secondary_clk_in = 1'b0;
    fast_internal_osc = 1'b0;
    slow_internal_osc = 1'b0;
    oscillator_startup_timer_done = 1'b0;
    #2;
    fork
      forever #40 primary_clk_in = ~primary_clk_in;
      forever #120 secondary_clk_in = ~secondary_clk_in;
      forever #64 fast_internal_osc = ~fast_internal_osc;
      forever #200 slow_internal_osc = ~slow_internal_osc;
      #1000 oscillator_startup_timer_done = 1'b1;
    join
  end

endmodule : css_osc_model

`default_nettype wire

// *** css_pkg.sv ***
// Package of constants and types for the clock source switch.
`default_nettype none

package css_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [1:0] OSC_CTRL_ADDR = 2'h0;
  localparam logic [1:0] OSC_TUNE_ADDR = 2'h1;
  localparam logic [1:0] SEC_CTRL_ADDR = 2'h2;

  // Oscillator control register field positions.
  localparam int IDLE_BIT = 7;
  localparam int IFREQ_HI = 6;
  localparam int IFREQ_LO = 4;
  localparam int STARTUP_BIT = 3;
  localparam int ONE_BIT = 2;
  localparam int CSEL_HI = 1;
  localparam int CSEL_LO = 0;
  // Tuning register and secondary timer control field positions.
  localparam int LFS_BIT = 7;
  localparam int SEC_ACTIVE_BIT = 6;
  localparam int SEC_EN_BIT = 3;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CSEL_PRIMARY = 2'h0;
  localparam logic [1:0] CSEL_SECONDARY = 2'h1;
  localparam logic [1:0] CSEL_RESERVED = 2'h2;
  localparam logic [1:0] CSEL_INTERNAL = 2'h3;
  localparam logic [2:0] IFREQ_8MHZ = 3'h7;
  localparam logic [2:0] IFREQ_4MHZ = 3'h6;
  localparam logic [2:0] IFREQ_31KHZ = 3'h0;
  localparam logic [2:0] IFREQ_RESET = IFREQ_4MHZ;
  localparam logic [1:0] CSEL_RESET = CSEL_PRIMARY;
  localparam logic [2:0] PMODE_INT_A = 3'h0;
  localparam logic [2:0] PMODE_INT_B = 3'h1;
  localparam int LF_DIV_BIT = 7;
  localparam logic [6:0] LOW_SPEED_SYS_MHZ = 7'h18;
  localparam logic [5:0] USB_LOW_MHZ = 6'h06;
  localparam logic [5:0] USB_FULL_MHZ = 6'h30;

  // ---------------------------------------------------------------
  // Switch pause lengths in source clock cycles
  // ---------------------------------------------------------------
  localparam logic [1:0] OLD_CYCLES = 2'h2;
  localparam logic [1:0] NEW_CYCLES = 2'h3;

  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} css_src_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } css_bus_req_t;

endpackage : css_pkg

`default_nettype wire

// *** css_switch.sv ***
// Clock source selection, postscaler and glitch-free switch logic.
`default_nettype none

// Functional notes
// - Two-bit select picks one of three sources.
// - Writing select starts the source change.
// - Any reset clears select to primary.
// - Three-bit field picks internal postscaler frequency.
// - Frequency field changes internal output immediately.
// - Reset sets postscaler to 4 MHz.
// - Code 000 uses fast/256 or slow oscillator.
// - Watchdog clock always uses slow oscillator.
// - Startup flag set when primary runs after timeout.
// - Secondary active flag while secondary drives clock.
// - At most one source flag set.
// - Sleep instruction checks idle-on-sleep bit.
// - Secondary select ignored while secondary disabled.
// - Pause two old plus three new cycles.
// - Low-speed USB needs 24 MHz system, 6 MHz.
// - Primary mode fixed by configuration field.
// - Decode 11 internal, 01 secondary, 00 primary.
// - Decode frequency codes 111 down to 000.
// - Idle bit one gives Idle, zero Sleep.
module css_switch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire css_pkg::css_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic primary_clk_in,
  input wire logic secondary_clk_in,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  input wire logic [2:0] primary_mode_config,
  input wire logic oscillator_startup_timer_done,
  input wire logic sleep_exec,
  input wire logic usb_low_speed,
  input wire logic [6:0] sys_clk_mhz,
  output logic dev_clk,
  output logic wdt_clk,
  output logic switch_busy,
  output logic enter_idle,
  output logic enter_sleep,
  output logic usb_cfg_ok,
  output logic [5:0] usb_clk_mhz
);
  import css_pkg::*;

  // ---------------------------------------------------------------
  // Software-visible state
  // ---------------------------------------------------------------
  logic [1:0] clock_source_select_r;
  logic [2:0] internal_freq_select_r;
  logic idle_on_sleep_r;
  logic low_freq_source_select_r;
  logic secondary_osc_enable_r;
  logic startup_expired_flag_r;
  logic secondary_clock_active_r;
  logic [7:0] rdata_r;

  // ---------------------------------------------------------------
  // Source sampling and postscaler
  // ---------------------------------------------------------------
  logic [2:0] src_lvl;
  logic [2:0] src_prev_r;
  logic [2:0] src_rise;
  logic [2:0] src_fall;
  logic fast_prev_r;
  logic slow_lvl_r;
  logic [7:0] post_cnt_r;
  logic post_lvl;
  logic pri_lvl;

  // ---------------------------------------------------------------
  // Switch state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_OLD, ST_NEW} css_state_t;
  css_state_t state_r;
  css_src_t active_src_r;
  css_src_t target_src_r;
  css_src_t wanted_src;
  logic [1:0] edge_cnt_r;
  logic old_low_r;
  logic dev_clk_r;
  logic wdt_clk_r;
  logic switch_busy_r;
  logic enter_idle_r;
  logic enter_sleep_r;
  logic usb_cfg_ok_r;
  logic [5:0] usb_clk_mhz_r;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_source_select_r <= CSEL_RESET;
      internal_freq_select_r <= IFREQ_RESET;
      idle_on_sleep_r <= 1'b0;
    end
    else if (ce && bus_req.wr && bus_req.addr == OSC_CTRL_ADDR)
    begin
      idle_on_sleep_r <= bus_req.wdata[IDLE_BIT];
      internal_freq_select_r <= bus_req.wdata[IFREQ_HI:IFREQ_LO];
      // A secondary request without the oscillator enabled keeps the old choice.
      if (bus_req.wdata[CSEL_HI:CSEL_LO] != CSEL_SECONDARY || secondary_osc_enable_r)
      begin
        clock_source_select_r <= bus_req.wdata[CSEL_HI:CSEL_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_freq_source_select_r <= 1'b0;
    end
    else if (ce && bus_req.wr && bus_req.addr == OSC_TUNE_ADDR)
    begin
      low_freq_source_select_r <= bus_req.wdata[LFS_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      secondary_osc_enable_r <= 1'b0;
    end
    else if (ce && bus_req.wr && bus_req.addr == SEC_CTRL_ADDR)
    begin
      secondary_osc_enable_r <= bus_req.wdata[SEC_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_r <= 8'h00;
    end
    else if (ce)
    begin
      rdata_r <= 8'h00;
      if (bus_req.rd)
      begin
        case (bus_req.addr)
          OSC_CTRL_ADDR:
          begin
            rdata_r[IDLE_BIT] <= idle_on_sleep_r;
            rdata_r[IFREQ_HI:IFREQ_LO] <= internal_freq_select_r;
            rdata_r[STARTUP_BIT] <= startup_expired_flag_r;
            rdata_r[ONE_BIT] <= 1'b1;
            rdata_r[CSEL_HI:CSEL_LO] <= clock_source_select_r;
          end
          OSC_TUNE_ADDR:
          begin
            rdata_r[LFS_BIT] <= low_freq_source_select_r;
          end
          SEC_CTRL_ADDR:
          begin
            rdata_r[SEC_ACTIVE_BIT] <= secondary_clock_active_r;
            rdata_r[SEC_EN_BIT] <= secondary_osc_enable_r;
          end
          default:
          begin
            rdata_r <= 8'h00;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Postscaled internal clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fast_prev_r <= 1'b0;
      slow_lvl_r <= 1'b0;
      post_cnt_r <= 8'h00;
    end
    else if (ce)
    begin
      fast_prev_r <= fast_internal_osc;
      slow_lvl_r <= slow_internal_osc;
      if (fast_internal_osc && !fast_prev_r)
      begin
        post_cnt_r <= post_cnt_r + 8'h01;
      end
    end
  end

  // The mux is combinational so a new frequency code takes effect at once.
  always_comb
  begin
    post_lvl = 1'b0;
    if (internal_freq_select_r == IFREQ_8MHZ)
    begin
      post_lvl = fast_prev_r;
    end
    else if (internal_freq_select_r == IFREQ_31KHZ)
    begin
      post_lvl = low_freq_source_select_r ? post_cnt_r[LF_DIV_BIT] : slow_lvl_r;
    end
    else
    begin
      post_lvl = post_cnt_r[3'h6 - internal_freq_select_r];
    end
  end

  // Codes 000 and 001 of the configuration make the internal block the primary.
  assign pri_lvl = (primary_mode_config == PMODE_INT_A || primary_mode_config == PMODE_INT_B) ?
                   post_lvl : primary_clk_in;
  assign src_lvl = {post_lvl, secondary_clk_in, pri_lvl};

  for (genvar i = 0; i < 3; i++)
  begin : g_src
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        src_prev_r[i] <= 1'b0;
      end
      else if (ce)
      begin
        src_prev_r[i] <= src_lvl[i];
      end
    end
    assign src_rise[i] = src_lvl[i] && !src_prev_r[i];
    assign src_fall[i] = !src_lvl[i] && src_prev_r[i];
  end

  // ---------------------------------------------------------------
  // Source decode
  // ---------------------------------------------------------------
  always_comb
  begin
    wanted_src = SRC_PRI;
    case (clock_source_select_r)
      CSEL_PRIMARY: wanted_src = SRC_PRI;
      CSEL_SECONDARY: wanted_src = SRC_SEC;
      CSEL_INTERNAL: wanted_src = SRC_INT;
      CSEL_RESERVED: wanted_src = SRC_PRI;
      default: wanted_src = SRC_PRI;
    endcase
  end

  // ---------------------------------------------------------------
  // Glitch-free switch sequencer
  // ---------------------------------------------------------------
  // The old source is allowed to finish its high phase before the output
  // is parked low; the new source is then watched for three rising edges
  // so its first pulse reaching the device is a whole one.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_RUN;
      active_src_r <= SRC_PRI;
      target_src_r <= SRC_PRI;
      edge_cnt_r <= 2'h0;
      old_low_r <= 1'b0;
    end
    else if (ce)
    begin
      case (state_r)
        ST_RUN:
        begin
          if (wanted_src != active_src_r)
          begin
            state_r <= ST_OLD;
            target_src_r <= wanted_src;
            edge_cnt_r <= 2'h0;
            old_low_r <= 1'b0;
          end
        end
        ST_OLD:
        begin
          if (src_fall[active_src_r])
          begin
            old_low_r <= 1'b1;
            if (edge_cnt_r == OLD_CYCLES - 2'h1)
            begin
              state_r <= ST_NEW;
              edge_cnt_r <= 2'h0;
            end
            else
            begin
              edge_cnt_r <= edge_cnt_r + 2'h1;
            end
          end
        end
        ST_NEW:
        begin
          if (src_rise[target_src_r])
          begin
            if (edge_cnt_r == NEW_CYCLES - 2'h1)
            begin
              state_r <= ST_RUN;
              active_src_r <= target_src_r;
              edge_cnt_r <= 2'h0;
            end
            else
            begin
              edge_cnt_r <= edge_cnt_r + 2'h1;
            end
          end
        end
        default:
        begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dev_clk_r <= 1'b0;
      switch_busy_r <= 1'b0;
    end
    else if (ce)
    begin
      switch_busy_r <= (state_r != ST_RUN);
      case (state_r)
        ST_RUN: dev_clk_r <= src_lvl[active_src_r];
        ST_OLD: dev_clk_r <= (old_low_r || src_fall[active_src_r]) ? 1'b0 :
                             src_lvl[active_src_r];
        ST_NEW: dev_clk_r <= (src_rise[target_src_r] && edge_cnt_r == NEW_CYCLES - 2'h1) ?
                             1'b1 : 1'b0;
        default: dev_clk_r <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Both flags come from the settled source, so they can never be set together.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      startup_expired_flag_r <= 1'b0;
      secondary_clock_active_r <= 1'b0;
    end
    else if (ce && state_r == ST_RUN)
    begin
      startup_expired_flag_r <= oscillator_startup_timer_done &&
                                active_src_r == SRC_PRI;
      secondary_clock_active_r <= (active_src_r == SRC_SEC);
    end
  end

  // ---------------------------------------------------------------
  // Watchdog clock, sleep decision and USB clock check
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wdt_clk_r <= 1'b0;
      enter_idle_r <= 1'b0;
      enter_sleep_r <= 1'b0;
    end
    else if (ce)
    begin
      wdt_clk_r <= slow_lvl_r;
      enter_idle_r <= sleep_exec && idle_on_sleep_r;
      enter_sleep_r <= sleep_exec && !idle_on_sleep_r;
    end
  end

  // Only the clock ratio is checked here; the divider tables live elsewhere.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      usb_cfg_ok_r <= 1'b0;
      usb_clk_mhz_r <= USB_FULL_MHZ;
    end
    else if (ce)
    begin
      usb_cfg_ok_r <= !usb_low_speed || sys_clk_mhz == LOW_SPEED_SYS_MHZ;
      usb_clk_mhz_r <= usb_low_speed ? USB_LOW_MHZ : USB_FULL_MHZ;
    end
  end

  assign rdata = rdata_r;
  assign dev_clk = dev_clk_r;
  assign wdt_clk = wdt_clk_r;
  assign switch_busy = switch_busy_r;
  assign enter_idle = enter_idle_r;
  assign enter_sleep = enter_sleep_r;
  assign usb_cfg_ok = usb_cfg_ok_r;
  assign usb_clk_mhz = usb_clk_mhz_r;

endmodule : css_switch

`default_nettype wire

// *** css_switch_sva.sv ***
// Concurrent checks on the ports of the clock source switch.
`default_nettype none

module css_switch_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sleep_exec,
  input wire logic enter_idle,
  input wire logic enter_sleep,
  input wire logic usb_low_speed,
  input wire logic [6:0] sys_clk_mhz,
  input wire logic usb_cfg_ok,
  input wire logic [5:0] usb_clk_mhz,
  input wire logic slow_internal_osc,
  input wire logic wdt_clk,
  input wire logic switch_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_SLEEP_ONE: assert property (sleep_exec |=> enter_idle != enter_sleep)
    else $error("sleep request gave no single mode pulse");
  AST_SLEEP_QUIET: assert property (!sleep_exec |=> !enter_idle && !enter_sleep)
    else $error("mode pulse without sleep request");
  AST_USB_LOW: assert property (usb_low_speed |=> usb_clk_mhz == USB_LOW_MHZ)
    else $error("low speed usb clock wrong");
  AST_USB_FULL: assert property (!usb_low_speed |=> usb_clk_mhz == USB_FULL_MHZ)
    else $error("full speed usb clock wrong");
  AST_USB_CFG: assert property (usb_low_speed && sys_clk_mhz != LOW_SPEED_SYS_MHZ
    |=> !usb_cfg_ok)
    else $error("bad low speed system clock accepted");
  // Two flops stand between the slow oscillator and the watchdog clock; both freeze with ce.
  AST_WDT_SLOW: assert property ($past(rstn, 2) && $past(ce) && $past(ce, 2) |->
    wdt_clk == $past(slow_internal_osc, 2))
    else $error("watchdog clock does not follow slow oscillator");
  AST_PAUSE_MIN: assert property ($rose(switch_busy) |-> switch_busy[*8])
    else $error("switch pause too short");
  AST_PAUSE_MAX: assert property ($rose(switch_busy) |-> ##[1:400] !switch_busy)
    else $error("switch pause too long");

endmodule : css_switch_sva

`default_nettype wire

// *** css_switch_tb.sv ***
// Self-checking testbench for the clock source switch.
`default_nettype none

module css_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;

  localparam int PRI_P = 10;
  localparam int SEC_P = 30;
  localparam int FAST_P = 16;
  localparam int SLOW_P = 50;
  localparam int LIMIT = 60000;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  css_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic primary_clk_in, secondary_clk_in, fast_internal_osc, slow_internal_osc;
  logic oscillator_startup_timer_done;
  logic [2:0] primary_mode_config = 3'h2;
  logic sleep_exec = 1'b0;
  logic usb_low_speed = 1'b0;
  logic [6:0] sys_clk_mhz = 7'h30;
  logic dev_clk, wdt_clk, switch_busy, enter_idle, enter_sleep, usb_cfg_ok;
  logic [5:0] usb_clk_mhz;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [6:0] usys [3] = '{7'h18, 7'h30, 7'h30};
  logic ulow [3] = '{1'b1, 1'b1, 1'b0};

  always #4 clk = ~clk;

  css_osc_model css_osc_model_i (.primary_clk_in(primary_clk_in),
    .secondary_clk_in(secondary_clk_in), .fast_internal_osc(fast_internal_osc),
    .slow_internal_osc(slow_internal_osc),
    .oscillator_startup_timer_done(oscillator_startup_timer_done));

  css_switch css_switch_i (.clk(clk), .rstn(rstn), .ce(ce), .bus_req(bus_req),
    .rdata(rdata), .primary_clk_in(primary_clk_in), .secondary_clk_in(secondary_clk_in),
    .fast_internal_osc(fast_internal_osc), .slow_internal_osc(slow_internal_osc),
    .primary_mode_config(primary_mode_config),
    .oscillator_startup_timer_done(oscillator_startup_timer_done),
    .sleep_exec(sleep_exec), .usb_low_speed(usb_low_speed), .sys_clk_mhz(sys_clk_mhz),
    .dev_clk(dev_clk), .wdt_clk(wdt_clk), .switch_busy(switch_busy),
    .enter_idle(enter_idle), .enter_sleep(enter_sleep), .usb_cfg_ok(usb_cfg_ok),
    .usb_clk_mhz(usb_clk_mhz));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rv = rdata;
    chk({8'h00, rv}, {8'h00, exp}, msg);
  endtask : rchk

  // Sampling on the falling clock edge keeps clear of the registered output's update.
  task automatic period(input int exp, input string msg);
    int n;
    int k;
    for (int m = 0; m < 2; m++)
    begin
      n = 0;
      k = 0;
      while (dev_clk !== 1'b0 && k < 9000) begin @(negedge clk); k++; end
      while (dev_clk !== 1'b1 && k < 9000) begin @(negedge clk); k++; end
      while (dev_clk === 1'b1 && n < 9000) begin @(negedge clk); n++; end
      while (dev_clk === 1'b0 && n < 9000) begin @(negedge clk); n++; end
    end
    chk(16'(n), 16'(exp), msg);
  endtask : period

  // Inside a pause at most one old-source pulse and the first new pulse may show.
  task automatic switch_to(input logic [7:0] d);
    int k;
    int rises;
    logic seen;
    logic last;
    k = 0;
    rises = 0;
    seen = 1'b0;
    last = dev_clk;
    wr(OSC_CTRL_ADDR, d);
    while (k < 2000 && !(seen && switch_busy === 1'b0))
    begin
      @(negedge clk);
      k++;
      if (switch_busy === 1'b1)
        seen = 1'b1;
      if (switch_busy === 1'b1 && dev_clk === 1'b1 && last === 1'b0)
        rises++;
      last = dev_clk;
    end
    chk({15'h0, seen}, 16'h1, "no switch pause");
    chk({15'h0, switch_busy}, 16'h0, "pause not over");
    chk({15'h0, rises <= 2}, 16'h1, "clock pulses inside pause");
  endtask : switch_to

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (200) @(posedge clk);
    rchk(OSC_CTRL_ADDR, 8'h6C, "ctrl reset");
    rchk(OSC_TUNE_ADDR, 8'h00, "tune reset");
    rchk(SEC_CTRL_ADDR, 8'h00, "sec reset");
    wr(2'h3, 8'hFF);
    rchk(2'h3, 8'h00, "unmapped read");
    period(PRI_P, "primary period");
    end_test("reset");
    wr(OSC_CTRL_ADDR, 8'h61);
    rchk(OSC_CTRL_ADDR, 8'h6C, "secondary taken while disabled");
    wr(SEC_CTRL_ADDR, 8'h08);
    switch_to(8'h61);
    rchk(SEC_CTRL_ADDR, 8'h48, "secondary flag");
    rchk(OSC_CTRL_ADDR, 8'h65, "ctrl on secondary");
    period(SEC_P, "secondary period");
    end_test("secondary");
    switch_to(8'h63);
    rchk(SEC_CTRL_ADDR, 8'h08, "flag after leaving secondary");
    for (int c = 7; c >= 1; c--)
    begin
      wr(OSC_CTRL_ADDR, {1'b0, 3'(c), 4'h3});
      period(FAST_P << (7 - c), "postscaler period");
    end
    wr(OSC_CTRL_ADDR, 8'h03);
    period(SLOW_P, "slow low freq");
    wr(OSC_TUNE_ADDR, 8'h80);
    period(FAST_P * 256, "divided low freq");
    rchk(OSC_TUNE_ADDR, 8'h80, "tune readback");
    rchk(OSC_CTRL_ADDR, 8'h07, "ctrl on internal");
    end_test("internal");
    switch_to(8'h60);
    rchk(OSC_CTRL_ADDR, 8'h6C, "startup flag back on primary");
    period(PRI_P, "primary again");
    wr(OSC_CTRL_ADDR, 8'h62);
    rchk(OSC_CTRL_ADDR, 8'h6E, "reserved select readback");
    chk({15'h0, switch_busy}, 16'h0, "reserved select switched");
    for (int i = 0; i < 2; i++)
    begin
      wr(OSC_CTRL_ADDR, {i[0], 7'h60});
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      #1 chk({15'h0, enter_idle}, 16'(i), "idle pulse");
      chk({15'h0, enter_sleep}, 16'(1 - i), "sleep pulse");
    end
    end_test("sleep");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      usb_low_speed <= ulow[i];
      sys_clk_mhz <= usys[i];
      repeat (2) @(posedge clk);
      #1 chk({15'h0, usb_cfg_ok}, 16'(i != 1), "usb config");
      chk({10'h0, usb_clk_mhz}, ulow[i] ? 16'h6 : 16'h30, "usb clock");
    end
    end_test("usb");
    @(posedge clk);
    ce <= 1'b0;
    wr(SEC_CTRL_ADDR, 8'h00);
    ce <= 1'b1;
    rchk(SEC_CTRL_ADDR, 8'h08, "write taken while frozen");
    end_test("clock enable");
    wr(OSC_TUNE_ADDR, 8'h80);
    @(posedge clk);
    rstn <= 1'b0;
    primary_mode_config <= 3'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(OSC_TUNE_ADDR, 8'h00, "tune after reset");
    rchk(OSC_CTRL_ADDR, 8'h6C, "ctrl after reset");
    period(FAST_P * 2, "internal block as primary");
    end_test("mid reset");
    report_and_stop();
  end

endmodule : css_switch_tb

bind css_switch css_switch_sva css_switch_sva_i (.clk(clk), .rstn(rstn), .ce(ce),
  .sleep_exec(sleep_exec), .enter_idle(enter_idle), .enter_sleep(enter_sleep),
  .usb_low_speed(usb_low_speed), .sys_clk_mhz(sys_clk_mhz), .usb_cfg_ok(usb_cfg_ok),
  .usb_clk_mhz(usb_clk_mhz), .slow_internal_osc(slow_internal_osc), .wdt_clk(wdt_clk),
  .switch_busy(switch_busy));

`default_nettype wire
